// >>> design/mrc_defines.svh
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define MRC_CLK_HZ          20000000
`define MRC_DEBOUNCE_MS     10
`define MRC_DEBOUNCE_CYC    ((`MRC_CLK_HZ / 1000) * `MRC_DEBOUNCE_MS)
`define MRC_BAUD_MIN        300
`define MRC_BAUD_MAX        19200
`define MRC_BAUD_DEFAULT    9600
`define MRC_BAUD_DIV_DEF    (`MRC_CLK_HZ / `MRC_BAUD_DEFAULT)
`define MRC_BAUD_DIV_MIN    (`MRC_CLK_HZ / `MRC_BAUD_MAX)
`define MRC_BAUD_DIV_MAX    (`MRC_CLK_HZ / `MRC_BAUD_MIN)
`define MRC_BLINK_CYC       4000000

// ------------------------------------------------------------
// encodings and reset values
// ------------------------------------------------------------
`define MRC_PAR_NONE        2'h0
`define MRC_PAR_ODD         2'h1
`define MRC_PAR_EVEN        2'h2
`define MRC_STOP_ONE        1'h0
`define MRC_STOP_TWO        1'h1
`define MRC_NODE_ADDR_RST   8'h01
`define MRC_READING_W       24
`define MRC_FIFO_DEPTH      8

`endif

// >>> design/mrc_pkg.sv
package mrc_pkg;
  typedef enum logic [1:0] {
    MRC_PAR_NONE_E = 2'b00,
    MRC_PAR_ODD_E  = 2'b01,
    MRC_PAR_EVEN_E = 2'b10
  } mrc_parity_t;

  typedef enum logic [2:0] {
    MRC_TX_IDLE   = 3'b000,
    MRC_TX_START  = 3'b001,
    MRC_TX_DATA   = 3'b010,
    MRC_TX_PARITY = 3'b011,
    MRC_TX_STOP   = 3'b100
  } mrc_tx_state_t;
endpackage

// >>> design/mrc_fifo.sv
module mrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> design/mrc_debounce.sv
`include "mrc_defines.svh"

module mrc_debounce #(
  parameter int DEB_CYC = `MRC_DEBOUNCE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_low_b,
  output logic      level_r,
  output logic      rise_r
);
  // ------------------------------------------------------------
  // three-stage sync, stage two and three must agree
  // ------------------------------------------------------------
  logic [2:0]  sync_r;
  logic [31:0] cnt_r;
  logic        act;

  assign act = (sync_r[1] == sync_r[2]) ? ~sync_r[2] : level_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= 3'h7;
    end else begin
      sync_r <= {sync_r[1:0], pin_low_b};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= '0;
      level_r <= 1'b0;
      rise_r  <= 1'b0;
    end else begin
      rise_r <= 1'b0;
      if (act == level_r) begin
        cnt_r <= '0;
      end else if (cnt_r >= 32'(DEB_CYC - 1)) begin
        cnt_r   <= '0;
        level_r <= act;
        rise_r  <= act;
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end
endmodule

// >>> design/mrc_top.sv
// Functional notes
// - tare closure zeroes the displayed reading.
// - peak input held: show stored maximum, flashing.
// - valley input held: show stored minimum, flashing.
// - reset input with scope zero does full hard reset, shows indication.
// - reset input with scope one clears only max and min.
// - hold input grounded freezes the displayed value.
// - during hold, sampling, outputs and max/min tracking continue.
// - lockout blocks configuration changes and storage writes.
// - lockout in run mode blocks setup entry from menu button.
// - print input with print enable starts serial printout.
// - print input with latch-clear enable clears latched alarms.
// - parity code 0 none, 1 odd, 2 even frames characters.
// - stop select 0 gives one stop bit, 1 gives two.
// - comm settings change only when all five lock bits are zero.
// - second logic-level serial pair uses identical framing.
// - four outputs: two setpoints, then alarm one and alarm two.
// - baud from 300 to 19200, default 9600.
`include "mrc_defines.svh"

module mrc_top #(
  parameter int RW      = `MRC_READING_W,
  parameter int DEB_CYC = `MRC_DEBOUNCE_CYC,
  parameter int BLINK   = `MRC_BLINK_CYC,
  parameter int FDEPTH  = `MRC_FIFO_DEPTH
) (
  input  wire logic          CLOCK,
  input  wire logic          RST_B,
  input  wire logic          TARE_B,
  input  wire logic          PEAK_SEL_B,
  input  wire logic          VALLEY_SEL_B,
  input  wire logic          EXT_RESET_B,
  input  wire logic          HOLD_B,
  input  wire logic          LOCKOUT_B,
  input  wire logic          PRINT_ALARM_B,
  input  wire logic          MENU_PRESS,
  input  wire logic          SAMPLE_VALID,
  input  wire logic [RW-1:0] SAMPLE,
  input  wire logic          RESET_SCOPE_SELECT,
  input  wire logic          PRINT_ON_LINE_SELECT,
  input  wire logic          ALARM_LATCH_CLEAR_SELECT,
  input  wire logic          CFG_WRITE,
  input  wire logic [1:0]    CFG_PARITY_SELECT,
  input  wire logic          CFG_STOP_BIT_SELECT,
  input  wire logic [7:0]    CFG_NODE_ADDRESS,
  input  wire logic [16:0]   CFG_BAUD_DIV,
  input  wire logic [4:0]    CFG_COMM_LOCK_BITS,
  input  wire logic          ALARM_SET_ONE,
  input  wire logic          ALARM_SET_TWO,
  input  wire logic          SETPOINT_ONE_IN,
  input  wire logic          SETPOINT_TWO_IN,
  input  wire logic [7:0]    TX_DATA,
  input  wire logic          TX_VALID,
  output logic               TX_READY,
  output logic [RW-1:0]      DISPLAY_VALUE,
  output logic               DISPLAY_FLASH,
  output logic [RW-1:0]      TARE_OFFSET,
  output logic [RW-1:0]      STORED_MAX_READING,
  output logic [RW-1:0]      STORED_MIN_READING,
  output logic               HARD_RESET_INDICATION,
  output logic               SETUP_MODE,
  output logic               NVM_WRITE_ALLOWED,
  output logic               PRINT_START,
  output logic [1:0]         PARITY_SELECT,
  output logic               STOP_BIT_SELECT,
  output logic [7:0]         NODE_ADDRESS,
  output logic [16:0]        BAUD_DIV,
  output logic [4:0]         COMM_LOCK_BITS,
  output logic               SETPOINT_ONE_OUT,
  output logic               SETPOINT_TWO_OUT,
  output logic               ALARM_ONE_OUT,
  output logic               ALARM_TWO_OUT,
  output logic               SER_TX,
  output logic               SER_TX_OE,
  output logic               AUX_TX
);
  // ------------------------------------------------------------
  // reset release and input conditioning
  // ------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  logic [6:0] pin_b;
  logic [6:0] lvl;
  logic [6:0] evt;
  assign pin_b = {PRINT_ALARM_B, LOCKOUT_B, HOLD_B, EXT_RESET_B, VALLEY_SEL_B, PEAK_SEL_B, TARE_B};
  for (genvar i = 0; i < 7; i++) begin : g_in
    mrc_debounce #(.DEB_CYC(DEB_CYC)) u_deb (
      .clk       (CLOCK),
      .rst_n     (rst_n),
      .pin_low_b (pin_b[i]),
      .level_r   (lvl[i]),
      .rise_r    (evt[i])
    );
  end
  logic tare_ev;
  logic peak_on;
  logic valley_on;
  logic reset_ev;
  logic hold_on;
  logic lock_on;
  logic print_ev;
  assign tare_ev   = evt[0];
  assign peak_on   = lvl[1];
  assign valley_on = lvl[2];
  assign reset_ev  = evt[3];
  assign hold_on   = lvl[4];
  assign lock_on   = lvl[5];
  assign print_ev  = evt[6];

  logic hard_rst;
  logic pv_clr;
  assign hard_rst = reset_ev && !RESET_SCOPE_SELECT;
  assign pv_clr   = reset_ev &&  RESET_SCOPE_SELECT;

  // ------------------------------------------------------------
  // reading, tare, max/min tracking
  // ------------------------------------------------------------
  logic [RW-1:0] live;
  assign live = SAMPLE - TARE_OFFSET;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      TARE_OFFSET <= '0;
    end else if (hard_rst) begin
      TARE_OFFSET <= '0;
    end else if (tare_ev) begin
      TARE_OFFSET <= SAMPLE;
    end
  end

  // tracking ignores hold on purpose
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      STORED_MAX_READING <= '0;
      STORED_MIN_READING <= '0;
    end else if (hard_rst || pv_clr) begin
      STORED_MAX_READING <= live;
      STORED_MIN_READING <= live;
    end else if (SAMPLE_VALID) begin
      if ($signed(live) > $signed(STORED_MAX_READING)) begin
        STORED_MAX_READING <= live;
      end
      if ($signed(live) < $signed(STORED_MIN_READING)) begin
        STORED_MIN_READING <= live;
      end
    end
  end

  // ------------------------------------------------------------
  // display path
  // ------------------------------------------------------------
  logic [31:0] blink_cnt_r;
  logic        blink_r;
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_r <= '0;
      blink_r     <= 1'b0;
    end else if (blink_cnt_r >= 32'(BLINK - 1)) begin
      blink_cnt_r <= '0;
      blink_r     <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      DISPLAY_VALUE <= '0;
      DISPLAY_FLASH <= 1'b0;
    end else begin
      DISPLAY_FLASH <= (peak_on || valley_on) && blink_r;
      if (hold_on) begin
        DISPLAY_VALUE <= DISPLAY_VALUE;
      end else if (peak_on) begin
        DISPLAY_VALUE <= STORED_MAX_READING;
      end else if (valley_on) begin
        DISPLAY_VALUE <= STORED_MIN_READING;
      end else if (tare_ev) begin
        DISPLAY_VALUE <= '0;
      end else begin
        DISPLAY_VALUE <= live;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      HARD_RESET_INDICATION <= 1'b0;
    end else begin
      HARD_RESET_INDICATION <= hard_rst;
    end
  end

  // ------------------------------------------------------------
  // lockout, setup entry, configuration
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      SETUP_MODE        <= 1'b0;
      NVM_WRITE_ALLOWED <= 1'b0;
    end else begin
      NVM_WRITE_ALLOWED <= !lock_on;
      if (hard_rst) begin
        SETUP_MODE <= 1'b0;
      end else if (MENU_PRESS && !SETUP_MODE && !lock_on) begin
        SETUP_MODE <= 1'b1;
      end
    end
  end

  logic cfg_ok;
  logic comm_ok;
  assign cfg_ok  = CFG_WRITE && !lock_on;
  assign comm_ok = cfg_ok && (COMM_LOCK_BITS == 5'h00);

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      COMM_LOCK_BITS  <= 5'h1f;
      PARITY_SELECT   <= `MRC_PAR_NONE;
      STOP_BIT_SELECT <= `MRC_STOP_ONE;
      NODE_ADDRESS    <= `MRC_NODE_ADDR_RST;
      BAUD_DIV        <= 17'(`MRC_BAUD_DIV_DEF);
    end else begin
      if (cfg_ok) begin
        COMM_LOCK_BITS <= CFG_COMM_LOCK_BITS;
      end
      if (comm_ok) begin
        if (CFG_PARITY_SELECT != 2'h3) begin
          PARITY_SELECT <= CFG_PARITY_SELECT;
        end
        STOP_BIT_SELECT <= CFG_STOP_BIT_SELECT;
        NODE_ADDRESS    <= CFG_NODE_ADDRESS;
        if (CFG_BAUD_DIV >= 17'(`MRC_BAUD_DIV_MIN) && CFG_BAUD_DIV <= 17'(`MRC_BAUD_DIV_MAX)) begin
          BAUD_DIV <= CFG_BAUD_DIV;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // setpoint and alarm outputs, latch clear, print
  // ------------------------------------------------------------
  logic alc_ev;
  assign alc_ev = print_ev && ALARM_LATCH_CLEAR_SELECT;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      SETPOINT_ONE_OUT <= 1'b0;
      SETPOINT_TWO_OUT <= 1'b0;
      ALARM_ONE_OUT    <= 1'b0;
      ALARM_TWO_OUT    <= 1'b0;
      PRINT_START      <= 1'b0;
    end else begin
      SETPOINT_ONE_OUT <= SETPOINT_ONE_IN;
      SETPOINT_TWO_OUT <= SETPOINT_TWO_IN;
      // a new alarm wins over the clear
      ALARM_ONE_OUT <= ALARM_SET_ONE || (ALARM_ONE_OUT && !alc_ev && !hard_rst);
      ALARM_TWO_OUT <= ALARM_SET_TWO || (ALARM_TWO_OUT && !alc_ev && !hard_rst);
      PRINT_START   <= print_ev && PRINT_ON_LINE_SELECT;
    end
  end

  // ------------------------------------------------------------
  // transmit fifo and serial framer
  // ------------------------------------------------------------
  logic [7:0] f_data;
  logic       f_valid;
  logic       f_ready;
  logic       f_in_ready;
  mrc_fifo #(.WIDTH(8), .DEPTH(FDEPTH)) u_fifo (
    .clk       (CLOCK),
    .rst_n     (rst_n),
    .in_data   (TX_DATA),
    .in_valid  (TX_VALID),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  mrc_pkg::mrc_tx_state_t st_r;
  logic [16:0] bdiv_r;
  logic [7:0]  sh_r;
  logic [2:0]  bit_r;
  logic        par_r;
  logic        stop2_r;
  logic        tick;
  assign tick    = (bdiv_r == 17'h00001);
  assign f_ready = (st_r == mrc_pkg::MRC_TX_IDLE);

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      TX_READY <= 1'b0;
    end else begin
      TX_READY <= f_in_ready;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= mrc_pkg::MRC_TX_IDLE;
      bdiv_r    <= '0;
      sh_r      <= '0;
      bit_r     <= '0;
      par_r     <= 1'b0;
      stop2_r   <= 1'b0;
      SER_TX    <= 1'b1;
      SER_TX_OE <= 1'b0;
      AUX_TX    <= 1'b1;
    end else begin
      bdiv_r <= tick ? BAUD_DIV : bdiv_r - 17'h00001;
      case (st_r)
        mrc_pkg::MRC_TX_IDLE: begin
          SER_TX    <= 1'b1;
          AUX_TX    <= 1'b1;
          SER_TX_OE <= 1'b0;
          if (f_valid) begin
            sh_r      <= f_data;
            par_r     <= (PARITY_SELECT == `MRC_PAR_ODD);
            stop2_r   <= STOP_BIT_SELECT;
            bdiv_r    <= BAUD_DIV;
            SER_TX    <= 1'b0;
            AUX_TX    <= 1'b0;
            SER_TX_OE <= 1'b1;
            st_r      <= mrc_pkg::MRC_TX_START;
          end
        end
        mrc_pkg::MRC_TX_START: begin
          if (tick) begin
            SER_TX <= sh_r[0];
            AUX_TX <= sh_r[0];
            bit_r  <= '0;
            st_r   <= mrc_pkg::MRC_TX_DATA;
          end
        end
        mrc_pkg::MRC_TX_DATA: begin
          if (tick) begin
            par_r <= par_r ^ sh_r[0];
            sh_r  <= {1'b0, sh_r[7:1]};
            if (bit_r == 3'h7) begin
              if (PARITY_SELECT != `MRC_PAR_NONE) begin
                SER_TX <= par_r ^ sh_r[0];
                AUX_TX <= par_r ^ sh_r[0];
                st_r   <= mrc_pkg::MRC_TX_PARITY;
              end else begin
                SER_TX <= 1'b1;
                AUX_TX <= 1'b1;
                st_r   <= mrc_pkg::MRC_TX_STOP;
              end
            end else begin
              SER_TX <= sh_r[1];
              AUX_TX <= sh_r[1];
              bit_r  <= bit_r + 3'h1;
            end
          end
        end
        mrc_pkg::MRC_TX_PARITY: begin
          if (tick) begin
            SER_TX <= 1'b1;
            AUX_TX <= 1'b1;
            st_r   <= mrc_pkg::MRC_TX_STOP;
          end
        end
        mrc_pkg::MRC_TX_STOP: begin
          if (tick) begin
            if (stop2_r) begin
              stop2_r <= 1'b0;
            end else begin
              SER_TX_OE <= 1'b0;
              st_r      <= mrc_pkg::MRC_TX_IDLE;
            end
          end
        end
        default: begin
          st_r <= mrc_pkg::MRC_TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_tare;
    @(posedge CLOCK) disable iff (!rst_n) tare_ev && !hard_rst |=> TARE_OFFSET == $past(SAMPLE);
  endproperty
  a_tare: assert property (p_tare) else $error("tare offset not taken");
  property p_hold;
    @(posedge CLOCK) disable iff (!rst_n) hold_on && $past(hold_on) |-> $stable(DISPLAY_VALUE);
  endproperty
  a_hold: assert property (p_hold) else $error("display moved in hold");
  property p_hard;
    @(posedge CLOCK) disable iff (!rst_n) reset_ev && !RESET_SCOPE_SELECT |=> HARD_RESET_INDICATION;
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset not shown");
  property p_pv;
    @(posedge CLOCK) disable iff (!rst_n) reset_ev && RESET_SCOPE_SELECT |=> !HARD_RESET_INDICATION;
  endproperty
  a_pv: assert property (p_pv) else $error("scope one did hard reset");
  property p_lock;
    @(posedge CLOCK) disable iff (!rst_n) lock_on && !SETUP_MODE |=> !SETUP_MODE;
  endproperty
  a_lock: assert property (p_lock) else $error("setup entered under lockout");
  property p_comm;
    @(posedge CLOCK) disable iff (!rst_n) COMM_LOCK_BITS != 5'h00 |=> $stable(PARITY_SELECT) && $stable(NODE_ADDRESS);
  endproperty
  a_comm: assert property (p_comm) else $error("comm setting changed while locked");
  property p_print;
    @(posedge CLOCK) disable iff (!rst_n) print_ev && PRINT_ON_LINE_SELECT |=> PRINT_START;
  endproperty
  a_print: assert property (p_print) else $error("print not started");
  property p_oe;
    @(posedge CLOCK) disable iff (!rst_n) st_r == mrc_pkg::MRC_TX_IDLE && !f_valid |=> !SER_TX_OE;
  endproperty
  a_oe: assert property (p_oe) else $error("driver on while idle");
  property p_aux;
    @(posedge CLOCK) disable iff (!rst_n) SER_TX_OE |-> SER_TX == AUX_TX;
  endproperty
  a_aux: assert property (p_aux) else $error("aux line differs");
  c_peak:  cover property (@(posedge CLOCK) disable iff (!rst_n) peak_on && DISPLAY_FLASH);
  c_frame: cover property (@(posedge CLOCK) disable iff (!rst_n)
                           st_r == mrc_pkg::MRC_TX_STOP ##1 st_r == mrc_pkg::MRC_TX_IDLE);
  c_alc:   cover property (@(posedge CLOCK) disable iff (!rst_n) alc_ev && ALARM_ONE_OUT);
endmodule

// >>> tb/mrc_host_model.sv
module mrc_host_model (
  input  wire logic        clk,
  input  wire logic        line,
  input  wire logic        oe,
  input  wire logic [16:0] div,
  input  wire logic [1:0]  par,
  input  wire logic        two,
  output logic      [7:0]  rx_byte,
  output int               frames,
  output int               bad
);
  timeunit 1ns;
  timeprecision 1ns;

  task automatic gap();
    repeat (div) @(posedge clk);
  endtask

  // samples each bit in its centre
  initial begin
    frames = 0;
    bad = 0;
    rx_byte = '0;
    forever begin
      @(negedge line);
      repeat (div / 2) @(posedge clk);
      if (line !== 1'b0 || oe !== 1'b1) bad++;
      for (int i = 0; i < 8; i++) begin
        gap();
        rx_byte[i] = line;
      end
      if (par != 2'h0) begin
        gap();
        if (line !== (^rx_byte ^ (par == 2'h1))) bad++;
      end
      repeat (two + 1) begin
        gap();
        if (line !== 1'b1 || oe !== 1'b1) bad++;
      end
      frames++;
    end
  end
endmodule

// >>> tb/tb_mrc_top.sv
module tb_mrc_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CLOCK, RST_B, TARE_B, PEAK_SEL_B, VALLEY_SEL_B, EXT_RESET_B, HOLD_B, LOCKOUT_B;
  logic        PRINT_ALARM_B, MENU_PRESS, SAMPLE_VALID, RESET_SCOPE_SELECT, PRINT_ON_LINE_SELECT;
  logic        ALARM_LATCH_CLEAR_SELECT, CFG_WRITE, CFG_STOP_BIT_SELECT, ALARM_SET_ONE, ALARM_SET_TWO;
  logic        SETPOINT_ONE_IN, SETPOINT_TWO_IN, TX_VALID, TX_READY, DISPLAY_FLASH, HARD_RESET_INDICATION;
  logic        SETUP_MODE, NVM_WRITE_ALLOWED, PRINT_START, STOP_BIT_SELECT, SETPOINT_ONE_OUT;
  logic        SETPOINT_TWO_OUT, ALARM_ONE_OUT, ALARM_TWO_OUT, SER_TX, SER_TX_OE, AUX_TX;
  logic [1:0]  CFG_PARITY_SELECT, PARITY_SELECT;
  logic [4:0]  CFG_COMM_LOCK_BITS, COMM_LOCK_BITS;
  logic [7:0]  CFG_NODE_ADDRESS, NODE_ADDRESS, TX_DATA, rx_byte;
  logic [16:0] CFG_BAUD_DIV, BAUD_DIV;
  logic [23:0] SAMPLE, DISPLAY_VALUE, TARE_OFFSET, STORED_MAX_READING, STORED_MIN_READING;
  int          fails, check_count, frames, bad, aux_bad, n_hr, n_pr, n_fl;

  mrc_top #(.DEB_CYC(4), .BLINK(2)) mrc_top_i (.*);
  mrc_host_model mrc_host_model_i (.clk(CLOCK), .line(SER_TX), .oe(SER_TX_OE), .div(BAUD_DIV),
    .par(PARITY_SELECT), .two(STOP_BIT_SELECT), .rx_byte(rx_byte), .frames(frames), .bad(bad));

  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    if (HARD_RESET_INDICATION === 1'b1) n_hr++;
    if (PRINT_START === 1'b1) n_pr++;
    if (DISPLAY_FLASH === 1'b1) n_fl++;
    if (SER_TX_OE === 1'b1 && AUX_TX !== SER_TX) aux_bad++;
  end

  task automatic final_report();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    check_count++;
    if (!ok) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // contact change, then time for sync and debounce
  task automatic pin(ref logic p, input logic v);
    @(negedge CLOCK);
    p = v;
    repeat (14) @(negedge CLOCK);
  endtask

  task automatic smp(input logic [23:0] v);
    @(negedge CLOCK);
    SAMPLE = v;
    SAMPLE_VALID = 1'b1;
    @(negedge CLOCK);
    SAMPLE_VALID = 1'b0;
    repeat (2) @(negedge CLOCK);
  endtask

  task automatic cfg(input logic [1:0] p, input logic s, input logic [16:0] d, input logic [4:0] l);
    @(negedge CLOCK);
    {CFG_PARITY_SELECT, CFG_STOP_BIT_SELECT, CFG_BAUD_DIV, CFG_COMM_LOCK_BITS} = {p, s, d, l};
    CFG_NODE_ADDRESS = 8'h05;
    CFG_WRITE = 1'b1;
    @(negedge CLOCK);
    CFG_WRITE = 1'b0;
    @(negedge CLOCK);
  endtask

  task automatic t_view();
    smp(24'h5);
    smp(24'hfffffe);
    smp(24'h9);
    smp(24'h3);
    n_fl = 0;
    pin(PEAK_SEL_B, 1'b0);
    chk(DISPLAY_VALUE === 24'h9 && STORED_MAX_READING === 24'h9 && n_fl > 0, "peak view");
    pin(PEAK_SEL_B, 1'b1);
    n_fl = 0;
    pin(VALLEY_SEL_B, 1'b0);
    chk(DISPLAY_VALUE === 24'hfffffe && STORED_MIN_READING === 24'hfffffe && n_fl > 0, "valley view");
    pin(VALLEY_SEL_B, 1'b1);
    chk(DISPLAY_VALUE === 24'h3 && DISPLAY_FLASH === 1'b0, "live view");
    pin(HOLD_B, 1'b0);
    smp(24'h20);
    chk(DISPLAY_VALUE === 24'h3, "hold");
    chk(STORED_MAX_READING === 24'h20, "max during hold");
    pin(HOLD_B, 1'b1);
  endtask

  task automatic t_events();
    smp(24'h7);
    pin(TARE_B, 1'b0);
    smp(24'h9);
    chk(TARE_OFFSET === 24'h7 && DISPLAY_VALUE === 24'h2, "tare");
    pin(TARE_B, 1'b1);
    RESET_SCOPE_SELECT = 1'b1;
    n_hr = 0;
    pin(EXT_RESET_B, 1'b0);
    pin(EXT_RESET_B, 1'b1);
    chk(STORED_MAX_READING === 24'h2 && STORED_MIN_READING === 24'h2, "max/min");
    chk(n_hr == 0 && TARE_OFFSET === 24'h7, "scope");
    RESET_SCOPE_SELECT = 1'b0;
    pin(EXT_RESET_B, 1'b0);
    chk(n_hr == 1 && TARE_OFFSET === '0, "hard reset");
    pin(EXT_RESET_B, 1'b1);
  endtask

  task automatic t_alarm();
    {SETPOINT_ONE_IN, SETPOINT_TWO_IN, ALARM_SET_ONE, ALARM_SET_TWO} = 4'hb;
    @(negedge CLOCK);
    {ALARM_SET_ONE, ALARM_SET_TWO} = 2'h0;
    repeat (3) @(negedge CLOCK);
    chk({SETPOINT_ONE_OUT, SETPOINT_TWO_OUT, ALARM_ONE_OUT, ALARM_TWO_OUT} === 4'hb, "outputs");
    PRINT_ON_LINE_SELECT = 1'b1;
    n_pr = 0;
    pin(PRINT_ALARM_B, 1'b0);
    pin(PRINT_ALARM_B, 1'b1);
    chk(n_pr == 1 && ALARM_ONE_OUT === 1'b1, "print");
    {PRINT_ON_LINE_SELECT, ALARM_LATCH_CLEAR_SELECT} = 2'h1;
    pin(PRINT_ALARM_B, 1'b0);
    pin(PRINT_ALARM_B, 1'b1);
    chk(n_pr == 1 && {ALARM_ONE_OUT, ALARM_TWO_OUT} === 2'h0, "latch clear");
  endtask

  task automatic t_cfg();
    pin(LOCKOUT_B, 1'b0);
    cfg(2'h0, 1'b0, 17'h00823, 5'h00);
    chk(COMM_LOCK_BITS === 5'h1f && NVM_WRITE_ALLOWED === 1'b0, "lockout");
    MENU_PRESS = 1'b1;
    @(negedge CLOCK);
    MENU_PRESS = 1'b0;
    repeat (2) @(negedge CLOCK);
    chk(SETUP_MODE === 1'b0, "setup");
    pin(LOCKOUT_B, 1'b1);
    MENU_PRESS = 1'b1;
    @(negedge CLOCK);
    MENU_PRESS = 1'b0;
    @(negedge CLOCK);
    chk(SETUP_MODE === 1'b1 && NVM_WRITE_ALLOWED === 1'b1, "setup entry");
    cfg(2'h2, 1'b1, 17'h00411, 5'h1f);
    chk(PARITY_SELECT === 2'h0 && BAUD_DIV === 17'h00823, "locked");
    cfg(2'h0, 1'b0, 17'h00823, 5'h00);
    cfg(2'h2, 1'b0, 17'h1046a, 5'h00);
    cfg(2'h3, 1'b0, 17'h00100, 5'h00);
    chk(COMM_LOCK_BITS === 5'h00 && PARITY_SELECT === 2'h2 && BAUD_DIV === 17'h1046a, "parity 3");
  endtask

  task automatic t_tx();
    int f;
    for (int p = 0; p < 3; p++) begin
      cfg(p[1:0], p == 2, 17'h00411, 5'h00);
      f = frames;
      TX_DATA = 8'ha5 ^ p[7:0];
      TX_VALID = 1'b1;
      do @(posedge CLOCK); while (TX_READY !== 1'b1);
      @(negedge CLOCK);
      TX_VALID = 1'b0;
      for (int i = 0; i < 14000 && frames == f; i++) @(negedge CLOCK);
      repeat (1100) @(negedge CLOCK);
      chk(rx_byte === (8'ha5 ^ p[7:0]) && bad == 0 && aux_bad == 0, "frame");
      chk(SER_TX_OE === 1'b0 && NODE_ADDRESS === 8'h05, "line release");
    end
  endtask

  // stream the fifo full without any drain time
  task automatic t_fill();
    int n;
    n = 0;
    TX_VALID = 1'b1;
    repeat (12) begin
      @(posedge CLOCK);
      if (TX_READY === 1'b1) n++;
    end
    @(negedge CLOCK);
    TX_VALID = 1'b0;
    chk(n >= 8 && n <= 10 && TX_READY === 1'b0, "fifo full");
  endtask

  initial begin
    {TARE_B, PEAK_SEL_B, VALLEY_SEL_B, EXT_RESET_B, HOLD_B, LOCKOUT_B, PRINT_ALARM_B} = '1;
    {MENU_PRESS, SAMPLE_VALID, RESET_SCOPE_SELECT, PRINT_ON_LINE_SELECT, ALARM_LATCH_CLEAR_SELECT} = '0;
    {CFG_WRITE, CFG_STOP_BIT_SELECT, ALARM_SET_ONE, ALARM_SET_TWO, SETPOINT_ONE_IN, SETPOINT_TWO_IN} = '0;
    {TX_VALID, CFG_PARITY_SELECT, CFG_COMM_LOCK_BITS, CFG_NODE_ADDRESS, TX_DATA, CFG_BAUD_DIV, SAMPLE} = '0;
    {fails, check_count, aux_bad, n_hr, n_pr, n_fl} = '0;
    RST_B = 1'b0;
    repeat (12) @(negedge CLOCK);
    RST_B = 1'b1;
    repeat (4) @(negedge CLOCK);
    chk(COMM_LOCK_BITS === 5'h1f && NODE_ADDRESS === 8'h01 && BAUD_DIV === 17'h00823, "reset");
    chk(SER_TX === 1'b1 && SER_TX_OE === 1'b0, "idle");
    t_view();
    t_events();
    t_alarm();
    t_cfg();
    t_tx();
    t_fill();
    final_report();
  end

  initial begin
    repeat (60000) @(posedge CLOCK);
    fails++;
    final_report();
  end
endmodule
